// >>> interrupt_vector_priority_unit.v
// Interrupt request, masking, priority and vectoring unit with AXI4-Lite register access
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "ivpu_regs.vh"

module interrupt_vector_priority_unit #(
  parameter ADDR_W = 18,
  parameter PC_W   = 16
) (
  input  wire              clk_sys,
  input  wire              sys_rst,
  // AXI4-Lite slave
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // Interrupt sources
  input  wire              watchdog_event,
  input  wire              prog_timer_req,
  input  wire              serial_req,
  input  wire              key_grp0_event,
  input  wire              key_grp1_event,
  input  wire              key_grp2_event,
  input  wire [3:0]        tick_event,
  input  wire              converter_event,
  // CPU core sequencer
  input  wire              insn_done,
  input  wire [3:0]        flag_reg_in,
  input  wire [PC_W-1:0]   pc_next_in,
  input  wire              ie_set,
  input  wire              ie_clr,
  input  wire              stack_pointer_one_wr,
  input  wire              stack_pointer_two_wr,
  output reg               cpu_int_req,
  output reg               ie_flag,
  output reg               flag_save,
  output reg  [3:0]        flag_save_data,
  output reg               stack_push,
  output reg  [PC_W-1:0]   stack_push_data,
  output reg               pc_load,
  output reg  [PC_W-1:0]   pc_load_value,
  output reg               irq
);

  localparam ST_IDLE = 2'h0;
  localparam ST_SAVE = 2'h1;
  localparam ST_PUSH = 2'h2;
  localparam ST_LOAD = 2'h3;

  localparam K_NONE   = 3'h0;
  localparam K_MASK   = 3'h1;
  localparam K_FLAG   = 3'h2;
  localparam K_STATUS = 3'h3;
  localparam K_IMASK  = 3'h4;
  localparam K_CORE   = 3'h5;

  // ****************************************************************
  // Address decode shared by the read and write paths
  // ****************************************************************
  function [2:0] reg_kind;
    input [ADDR_W-1:0] addr;
    reg   [15:0]       idx;
    begin
      idx = addr[17:2];
      if ((idx & `IDX_GROUP_SEL) == `IDX_MASK_BASE)
        reg_kind = K_MASK;
      else if ((idx & `IDX_GROUP_SEL) == `IDX_FLAG_BASE)
        reg_kind = K_FLAG;
      else if (idx == `IDX_IRQ_STATUS)
        reg_kind = K_STATUS;
      else if (idx == `IDX_IRQ_MASK)
        reg_kind = K_IMASK;
      else if (idx == `IDX_CORE_STATE)
        reg_kind = K_CORE;
      else
        reg_kind = K_NONE;
    end
  endfunction

  function [3:0] group_bits;
    input [1:0] grp;
    begin
      case (grp)
        2'd0:    group_bits = `BITS_KEY_GROUP0;
        2'd1:    group_bits = `BITS_KEY_GROUP12;
        2'd2:    group_bits = `BITS_CLOCK_TIMER;
        default: group_bits = `BITS_CONVERTER;
      endcase
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [15:0]       mask_q;
  reg  [15:0]       flag_q;
  reg  [2:0]        irq_status_q;
  reg  [2:0]        irq_mask_q;
  reg  [1:0]        state_q;
  reg  [3:0]        last_nibble_q;
  reg  [3:0]        cur_nibble_q;
  reg  [PC_W-1:0]   pc_saved_q;
  reg               nmi_pend_q;
  reg               sp_ok_q;
  reg  [1:0]        sp_half_q;
  reg  [ADDR_W-1:0] aw_addr_q;
  reg               aw_have_q;
  reg  [3:0]        w_data_q;
  reg               w_lane0_q;
  reg               w_have_q;

  wire [15:0]       flag_set;
  wire [`SRC_COUNT-1:0] req;
  wire              grant_any;
  wire [3:0]        grant_nibble;
  wire [2:0]        grant_src;
  wire              wr_go;
  wire [2:0]        wr_kind;
  wire [2:0]        rd_kind;
  wire              accept;
  wire              sp_break;
  reg  [31:0]       rd_word;
  integer           g;

  assign flag_set = {3'h0, converter_event, tick_event,
                     2'h0, key_grp2_event, key_grp1_event, 3'h0, key_grp0_event};

  // ****************************************************************
  // Request gathering and priority
  // ****************************************************************
  assign req[0] = nmi_pend_q;
  // Timer and serial requests arrive already gated by their own masks
  assign req[1] = ie_flag & prog_timer_req;
  assign req[2] = ie_flag & serial_req;
  assign req[3] = ie_flag & |(flag_q[3:0] & mask_q[3:0]);
  assign req[4] = ie_flag & |(flag_q[7:4] & mask_q[7:4]);
  assign req[5] = ie_flag & |(flag_q[11:8] & mask_q[11:8]);
  assign req[6] = ie_flag & |(flag_q[15:12] & mask_q[15:12]);

  vector_priority_select u_select (
    .req          (req),
    .grant_any    (grant_any),
    .grant_nibble (grant_nibble),
    .grant_src    (grant_src)
  );

  // Accept only at an instruction boundary with both stack pointers valid
  assign accept = (state_q == ST_IDLE) & insn_done & sp_ok_q & grant_any;

  // ****************************************************************
  // Processing sequence: save flags, push PC, load vector
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q         <= ST_IDLE;
      ie_flag         <= 1'b0;
      flag_save       <= 1'b0;
      flag_save_data  <= 4'h0;
      stack_push      <= 1'b0;
      stack_push_data <= {PC_W{1'b0}};
      pc_load         <= 1'b0;
      pc_load_value   <= {PC_W{1'b0}};
      pc_saved_q      <= {PC_W{1'b0}};
      cur_nibble_q    <= 4'h0;
      last_nibble_q   <= 4'h0;
      nmi_pend_q      <= 1'b0;
      cpu_int_req     <= 1'b0;
    end else begin
      flag_save   <= 1'b0;
      stack_push  <= 1'b0;
      pc_load     <= 1'b0;
      cpu_int_req <= (state_q == ST_IDLE) & sp_ok_q & grant_any & ~accept;
      // A new watchdog event wins over the clear of the one taken
      if (watchdog_event)
        nmi_pend_q <= 1'b1;
      else if (accept && grant_src == 3'h0)
        nmi_pend_q <= 1'b0;
      if (ie_set)
        ie_flag <= 1'b1;
      else if (ie_clr)
        ie_flag <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q        <= ST_SAVE;
            flag_save      <= 1'b1;
            flag_save_data <= flag_reg_in;
            ie_flag        <= 1'b0;
            pc_saved_q     <= pc_next_in;
            cur_nibble_q   <= grant_nibble;
          end
        end
        ST_SAVE: begin
          state_q         <= ST_PUSH;
          stack_push      <= 1'b1;
          stack_push_data <= pc_saved_q;
        end
        ST_PUSH: begin
          state_q       <= ST_LOAD;
          pc_load       <= 1'b1;
          pc_load_value <= {{(PC_W-16){1'b0}}, `VEC_PAGE, cur_nibble_q};
          last_nibble_q <= cur_nibble_q;
        end
        ST_LOAD: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Stack pointer pairing
  // ****************************************************************
  assign sp_break = (stack_pointer_one_wr ^ stack_pointer_two_wr) &
                    ~(stack_pointer_one_wr & sp_half_q[1]) &
                    ~(stack_pointer_two_wr & sp_half_q[0]);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      sp_ok_q   <= 1'b0;
      sp_half_q <= 2'b00;
    end else if (stack_pointer_one_wr & stack_pointer_two_wr) begin
      sp_ok_q   <= 1'b1;
      sp_half_q <= 2'b00;
    end else if (stack_pointer_one_wr | stack_pointer_two_wr) begin
      if (sp_break) begin
        sp_ok_q   <= 1'b0;
        sp_half_q <= {stack_pointer_two_wr, stack_pointer_one_wr};
      end else begin
        sp_ok_q   <= 1'b1;
        sp_half_q <= 2'b00;
      end
    end
  end

  // ****************************************************************
  // Flags, masks and event status
  // ****************************************************************
  assign wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_kind = reg_kind(aw_addr_q);

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      mask_q       <= {4{`MASK_RESET}};
      flag_q       <= {4{`FLAG_RESET}};
      irq_status_q <= `IRQ_STATUS_RESET;
      irq_mask_q   <= `IRQ_MASK_RESET;
      irq          <= 1'b0;
    end else begin
      for (g = 0; g < 4; g = g + 1) begin
        if (wr_go && w_lane0_q && wr_kind == K_MASK && aw_addr_q[3:2] == g)
          mask_q[4*g +: 4] <= w_data_q & group_bits(g[1:0]);
        // Writing one clears; a same-cycle event still sets
        if (wr_go && w_lane0_q && wr_kind == K_FLAG && aw_addr_q[3:2] == g)
          flag_q[4*g +: 4] <= ((flag_q[4*g +: 4] & ~w_data_q) | flag_set[4*g +: 4])
                              & group_bits(g[1:0]);
        else
          flag_q[4*g +: 4] <= (flag_q[4*g +: 4] | flag_set[4*g +: 4]) & group_bits(g[1:0]);
      end
      if (wr_go && w_lane0_q && wr_kind == K_IMASK)
        irq_mask_q <= w_data_q[2:0];
      if (wr_go && w_lane0_q && wr_kind == K_STATUS)
        irq_status_q <= (irq_status_q & ~w_data_q[2:0]) |
                        {sp_break, accept & (grant_src == 3'h0), accept & (grant_src != 3'h0)};
      else
        irq_status_q <= irq_status_q |
                        {sp_break, accept & (grant_src == 3'h0), accept & (grant_src != 3'h0)};
      irq <= |(irq_status_q & irq_mask_q);
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr_q     <= {ADDR_W{1'b0}};
      aw_have_q     <= 1'b0;
      w_data_q      <= 4'h0;
      w_lane0_q     <= 1'b0;
      w_have_q      <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_q     <= s_axi_awaddr;
        aw_have_q     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_q     <= s_axi_wdata[3:0];
        w_lane0_q    <= s_axi_wstrb[0];
        w_have_q     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_kind == K_NONE || wr_kind == K_CORE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign rd_kind = reg_kind(s_axi_araddr);

  always @* begin
    rd_word = 32'h0000_0000;
    case (rd_kind)
      K_MASK:   rd_word[3:0] = mask_q[4*s_axi_araddr[3:2] +: 4];
      K_FLAG:   rd_word[3:0] = flag_q[4*s_axi_araddr[3:2] +: 4];
      K_STATUS: rd_word[2:0] = irq_status_q;
      K_IMASK:  rd_word[2:0] = irq_mask_q;
      K_CORE:   rd_word[8:0] = {nmi_pend_q, last_nibble_q, state_q, sp_ok_q, ie_flag};
      default:  rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (rd_kind == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> ivpu_checker_sva.sv
// Concurrent checks of the interrupt sequence and register reads of the vector unit
`timescale 1ns/100ps
`default_nettype none
`include "ivpu_regs.vh"
module ivpu_checker #(
  parameter PC_W = 16
) (
  input wire logic            clk_sys,
  input wire logic            sys_rst,
  input wire logic            insn_done,
  input wire logic [3:0]      flag_reg_in,
  input wire logic [PC_W-1:0] pc_next_in,
  input wire logic            stack_pointer_one_wr,
  input wire logic            stack_pointer_two_wr,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic            s_axi_rvalid,
  input wire logic            ie_flag,
  input wire logic            flag_save,
  input wire logic [3:0]      flag_save_data,
  input wire logic            stack_push,
  input wire logic [PC_W-1:0] stack_push_data,
  input wire logic            pc_load,
  input wire logic [PC_W-1:0] pc_load_value
);
  // ****************************************************************
  // Pointer pairing mirror and assertions
  // ****************************************************************
  logic sp_ok_q;
  logic sp1_q;
  logic sp2_q;
  // One pointer alone leaves the other owed; the owed write restores acceptance
  always @(posedge clk_sys) begin
    if (sys_rst)
      {sp_ok_q, sp1_q, sp2_q} <= 3'h0;
    else if (stack_pointer_one_wr && stack_pointer_two_wr)
      {sp_ok_q, sp1_q, sp2_q} <= 3'h4;
    else if (stack_pointer_one_wr)
      {sp_ok_q, sp1_q, sp2_q} <= sp2_q ? 3'h4 : 3'h2;
    else if (stack_pointer_two_wr)
      {sp_ok_q, sp1_q, sp2_q} <= sp1_q ? 3'h4 : 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_save_push: assert property (flag_save |=> stack_push) else $error("push missing after save");
  a_push_load: assert property (stack_push |=> pc_load) else $error("vector load missing after push");
  a_vec_page: assert property (pc_load |-> pc_load_value[PC_W-1:4] == `VEC_PAGE)
    else $error("vector outside the vector page");
  a_vec_table: assert property (pc_load |-> pc_load_value[3:0] inside {`VEC_WATCHDOG, `VEC_PROG_TIMER,
    `VEC_SERIAL, `VEC_KEY_GROUP0, `VEC_KEY_GROUP12, `VEC_CLOCK_TIMER, `VEC_CONVERTER})
    else $error("vector nibble not assigned");
  a_ie_cleared: assert property (flag_save |-> !ie_flag) else $error("enable flag not cleared");
  a_save_data: assert property (flag_save |-> flag_save_data == $past(flag_reg_in))
    else $error("saved flags differ");
  a_push_data: assert property (stack_push |-> stack_push_data == $past(pc_next_in, 2))
    else $error("pushed address differs");
  a_on_boundary: assert property (flag_save |-> $past(insn_done)) else $error("accepted mid instruction");
  a_no_overlap: assert property (flag_save |=> !flag_save [*3]) else $error("sequence restarted early");
  a_sp_paired: assert property (flag_save |-> $past(sp_ok_q)) else $error("accepted with pointers unpaired");
  a_mask_needs_ie: assert property (pc_load && pc_load_value[3:0] != `VEC_WATCHDOG |-> $past(ie_flag, 3))
    else $error("maskable request taken with enable clear");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  c_wdt: cover property (pc_load && pc_load_value[3:0] == `VEC_WATCHDOG);
  c_key12: cover property (pc_load && pc_load_value[3:0] == `VEC_KEY_GROUP12);
  c_conv: cover property (pc_load && pc_load_value[3:0] == `VEC_CONVERTER);
endmodule
bind interrupt_vector_priority_unit ivpu_checker #(.PC_W(PC_W)) ivpu_checker_inst (.clk_sys, .sys_rst,
  .insn_done, .flag_reg_in, .pc_next_in, .stack_pointer_one_wr, .stack_pointer_two_wr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .ie_flag, .flag_save, .flag_save_data, .stack_push, .stack_push_data,
  .pc_load, .pc_load_value);
`default_nettype wire

// >>> ivpu_core_model.sv
// Behavioural core sequencer: instruction boundaries, flag register and next address
`timescale 1ns/100ps
`default_nettype none
module ivpu_core_model (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        slow,
  output logic             insn_done,
  output logic [3:0]       flag_reg_in,
  output logic [15:0]      pc_next_in
);
  logic [1:0] phase_q;
  // Slow mode spaces boundaries three cycles apart so accepts must wait
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      phase_q <= 2'h0;
      insn_done <= 1'h0;
      flag_reg_in <= 4'h0;
      pc_next_in <= 16'h0200;
    end else begin
      phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
      insn_done <= !slow || (phase_q == 2'h2);
      flag_reg_in <= flag_reg_in + 4'h3;
      if (insn_done)
        pc_next_in <= pc_next_in + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> ivpu_regs.vh
// Register indices, field layouts, reset values and vectors of the interrupt vector and priority unit
// Notes on behaviour
// - One flag and one mask per source, fixed places
// - Current instruction completes before interrupt processing
// - Step one: save flags, then clear enable
// - Step two: push next program counter to stack
// - Step three: load vector, fetch routine there
// - Request supplies only low four vector bits
// - Fixed priority order from watchdog down to converter
// - Key groups one and two share one vector
// - Flag interrupts only when mask and enable set
// - Flags clear on written one, reset to zero
// - Watchdog interrupt ignores masks and enable flag
// - Hold all interrupts until both stack pointers set
`ifndef IVPU_REGS_VH
`define IVPU_REGS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define IDX_KEY_GROUP0_MASK   16'hffe4
`define IDX_KEY_GROUP12_MASK  16'hffe5
`define IDX_CLOCK_TIMER_MASK  16'hffe6
`define IDX_CONVERTER_MASK    16'hffe7
`define IDX_KEY_GROUP0_FLAG   16'hfff4
`define IDX_KEY_GROUP12_FLAG  16'hfff5
`define IDX_CLOCK_TIMER_FLAG  16'hfff6
`define IDX_CONVERTER_FLAG    16'hfff7
`define IDX_MASK_BASE         16'hffe4
`define IDX_FLAG_BASE         16'hfff4
`define IDX_GROUP_SEL         16'hfffc
`define IDX_IRQ_STATUS        16'h0000
`define IDX_IRQ_MASK          16'h0001
`define IDX_CORE_STATE        16'h0002

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define BITS_KEY_GROUP0       4'h1
`define BITS_KEY_GROUP12      4'h3
`define BITS_CLOCK_TIMER      4'hf
`define BITS_CONVERTER        4'h1
`define MASK_RESET            4'h0
`define FLAG_RESET            4'h0
`define IRQ_STATUS_RESET      3'h0
`define IRQ_MASK_RESET        3'h0
`define EVT_MASKABLE_TAKEN    0
`define EVT_NMI_TAKEN         1
`define EVT_SP_UNPAIRED       2

// ****************************************************************
// Vectors: fixed page and per-source low nibble
// ****************************************************************
`define VEC_PAGE              12'h010
`define VEC_WATCHDOG          4'h0
`define VEC_PROG_TIMER        4'h4
`define VEC_SERIAL            4'h6
`define VEC_KEY_GROUP0        4'h8
`define VEC_KEY_GROUP12       4'ha
`define VEC_CLOCK_TIMER       4'hc
`define VEC_CONVERTER         4'he
`define SRC_COUNT             7

// ****************************************************************
// AXI responses
// ****************************************************************
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

`endif

// >>> tb_interrupt_vector_priority_unit.sv
// Self-checking bench for the interrupt vector and priority unit
`timescale 1ns/100ps
`default_nettype none
`include "ivpu_regs.vh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_interrupt_vector_priority_unit;
  logic        clk_sys = 1'h0, sys_rst = 1'h1, slow = 1'h0;
  logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rnd;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  ev = 9'h0;
  logic        prog_timer_req = 1'h0, serial_req = 1'h0, ie_set = 1'h0, ie_clr = 1'h0;
  logic        stack_pointer_one_wr = 1'h0, stack_pointer_two_wr = 1'h0;
  logic        insn_done, cpu_int_req, ie_flag, flag_save, stack_push, pc_load, irq;
  logic [3:0]  flag_reg_in, flag_save_data;
  logic [15:0] pc_next_in, stack_push_data, pc_load_value, ev_v;
  logic [33:0] r_q[$], ev_r;
  logic [1:0]  b_q[$], ev_b;
  logic [15:0] v_q[$];
  int          n_fail = 0, cmp_count = 0;
  logic [3:0]  bits_t[4] = '{`BITS_KEY_GROUP0, `BITS_KEY_GROUP12, `BITS_CLOCK_TIMER, `BITS_CONVERTER};
  logic [3:0]  vn_t[7] = '{4'h4, 4'h6, 4'h8, 4'ha, 4'ha, 4'hc, 4'he};
  logic [15:0] ci_t[7] = '{16'h0, 16'h0, `IDX_KEY_GROUP0_FLAG, `IDX_KEY_GROUP12_FLAG, `IDX_KEY_GROUP12_FLAG,
                           `IDX_CLOCK_TIMER_FLAG, `IDX_CONVERTER_FLAG};
  logic [3:0]  cv_t[7] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'hf, 4'h1};

  interrupt_vector_priority_unit interrupt_vector_priority_unit_inst (.clk_sys, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .watchdog_event(ev[0]), .prog_timer_req, .serial_req,
    .key_grp0_event(ev[1]), .key_grp1_event(ev[2]), .key_grp2_event(ev[3]), .tick_event(ev[7:4]),
    .converter_event(ev[8]), .insn_done, .flag_reg_in, .pc_next_in, .ie_set, .ie_clr, .stack_pointer_one_wr,
    .stack_pointer_two_wr, .cpu_int_req, .ie_flag, .flag_save, .flag_save_data, .stack_push, .stack_push_data,
    .pc_load, .pc_load_value, .irq);
  ivpu_core_model ivpu_core_model_inst (.clk_sys, .sys_rst, .slow, .insn_done, .flag_reg_in, .pc_next_in);

  always #10 clk_sys = ~clk_sys;

  // ****************************************************************
  // Result monitor: oldest note against each answer
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (!sys_rst && s_axi_bvalid && s_axi_bready) begin
      ev_b = b_q.pop_front();
      `CHK("bresp", ev_b, s_axi_bresp)
    end
    if (!sys_rst && s_axi_rvalid && s_axi_rready) begin
      ev_r = r_q.pop_front();
      `CHK("rdata", ev_r, {s_axi_rresp, s_axi_rdata})
    end
    if (!sys_rst && pc_load) begin
      ev_v = (v_q.size() != 0) ? v_q.pop_front() : 16'hxxxx;
      `CHK("pc_load_value", ev_v, pc_load_value)
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic a, w;
    b_q.push_back(er);
    @(posedge clk_sys);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    a = 1'h0;
    w = 1'h0;
    while (!(a && w)) begin
      @(posedge clk_sys);
      a = a | s_axi_awready;
      w = w | s_axi_wready;
      if (a) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    r_q.push_back({er, d});
    @(posedge clk_sys);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'h1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
  endtask
  task automatic pulse(input logic [8:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 9'h0;
  endtask
  task automatic spw(input logic a, input logic b);
    @(posedge clk_sys);
    stack_pointer_one_wr <= a;
    stack_pointer_two_wr <= b;
    @(posedge clk_sys);
    stack_pointer_one_wr <= 1'h0;
    stack_pointer_two_wr <= 1'h0;
  endtask
  task automatic iep();
    @(posedge clk_sys);
    ie_set <= 1'h1;
    @(posedge clk_sys);
    ie_set <= 1'h0;
  endtask
  task automatic wvec();
    while (v_q.size() != 0) @(posedge clk_sys);
    cyc(2);
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1ms;
    n_fail++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rnd = $urandom(32'h42df8f45);
    cyc(8);
    sys_rst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      rnd = $urandom;
      rd(16'(`IDX_MASK_BASE + i), 32'h0, `RESP_OKAY);
      rd(16'(`IDX_FLAG_BASE + i), 32'h0, `RESP_OKAY);
      wr(16'(`IDX_FLAG_BASE + i), 32'hf, `RESP_OKAY);
      wr(16'(`IDX_MASK_BASE + i), {rnd[31:4], 4'hf}, `RESP_OKAY);
      rd(16'(`IDX_MASK_BASE + i), {28'h0, bits_t[i]}, `RESP_OKAY);
    end
    wr(16'h0100, 32'h1, `RESP_SLVERR);
    rd(16'h0100, 32'h0, `RESP_SLVERR);
    // Watchdog must wait while one pointer is owed
    for (int k = 0; k < 2; k++) begin
      spw(k[0], !k[0]);
      pulse(9'h001);
      cyc(20);
      v_q.push_back({`VEC_PAGE, `VEC_WATCHDOG});
      spw(!k[0], k[0]);
      wvec();
    end
    // All sources but the watchdog at once; each service clears its own cause
    prog_timer_req <= 1'h1;
    serial_req <= 1'h1;
    pulse(9'h1fe);
    rd(`IDX_KEY_GROUP12_FLAG, 32'h3, `RESP_OKAY);
    for (int i = 0; i < 7; i++) begin
      slow <= i[0];
      v_q.push_back({`VEC_PAGE, vn_t[i]});
      iep();
      wvec();
      if (i == 0) prog_timer_req <= 1'h0;
      else if (i == 1) serial_req <= 1'h0;
      else wr(ci_t[i], {28'h0, cv_t[i]}, `RESP_OKAY);
    end
    wr(`IDX_CONVERTER_MASK, 32'h0, `RESP_OKAY);
    pulse(9'h100);
    iep();
    cyc(20);
    `CHK("cpu_int_req", 1'h0, cpu_int_req)
    rd(`IDX_CONVERTER_FLAG, 32'h1, `RESP_OKAY);
    v_q.push_back({`VEC_PAGE, `VEC_CONVERTER});
    wr(`IDX_CONVERTER_MASK, 32'h1, `RESP_OKAY);
    wvec();
    wr(`IDX_IRQ_STATUS, 32'h7, `RESP_OKAY);
    wr(`IDX_IRQ_MASK, 32'h1, `RESP_OKAY);
    cyc(3);
    `CHK("irq", 1'h0, irq)
    v_q.push_back({`VEC_PAGE, `VEC_CONVERTER});
    iep();
    wvec();
    cyc(2);
    `CHK("irq", 1'h1, irq)
    wr(`IDX_IRQ_STATUS, 32'h1, `RESP_OKAY);
    cyc(3);
    `CHK("irq", 1'h0, irq)
    rd(`IDX_CORE_STATE, 32'he2, `RESP_OKAY);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> vector_priority_select.v
// Fixed-priority selection of the winning request and its vector nibble
`timescale 1ns/100ps
`default_nettype none
`include "ivpu_regs.vh"

module vector_priority_select (
  input  wire [`SRC_COUNT-1:0] req,
  output reg                   grant_any,
  output reg  [3:0]            grant_nibble,
  output reg  [2:0]            grant_src
);

  function [3:0] nibble_of;
    input [2:0] src;
    begin
      case (src)
        3'h0:    nibble_of = `VEC_WATCHDOG;
        3'h1:    nibble_of = `VEC_PROG_TIMER;
        3'h2:    nibble_of = `VEC_SERIAL;
        3'h3:    nibble_of = `VEC_KEY_GROUP0;
        3'h4:    nibble_of = `VEC_KEY_GROUP12;
        3'h5:    nibble_of = `VEC_CLOCK_TIMER;
        default: nibble_of = `VEC_CONVERTER;
      endcase
    end
  endfunction

  integer i;

  // Scan from highest index to lowest so the last hit, the lowest index and highest priority, stands
  always @* begin
    grant_any    = 1'b0;
    grant_src    = 3'h0;
    grant_nibble = `VEC_WATCHDOG;
    for (i = `SRC_COUNT - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        grant_any    = 1'b1;
        grant_src    = i[2:0];
        grant_nibble = nibble_of(i[2:0]);
      end
    end
  end

endmodule
`default_nettype wire
